// ==== src/lowpower_pkg.sv ====
/*
 * Shared constants and carrier types for the low-power, pin, reset and mode logic.
 * Assumes a single 50 MHz system clock and a synchronous active-high reset.
 */
package lowpower_pkg;

	localparam int          CLK_MHZ          = 50;
	localparam int          CLK_PERIOD_NS    = 20;
	// Serial receive: sixteen samples per bit, centre sample at eight.
	localparam logic [3:0]  RX_SAMPLES       = 4'hf;
	localparam logic [3:0]  RX_CENTRE        = 4'h7;
	localparam logic [3:0]  RX_BITS          = 4'h9;
	localparam logic [7:0]  WRONLY_READ      = 8'hff;
	localparam logic [2:0]  MODE_MUX         = 3'h4;
	localparam logic [2:0]  MODE_MUX_ALT     = 3'h2;
	localparam logic [2:0]  MODE_UNDEF       = 3'h3;
	localparam logic [1:0]  RST_SYNC_RESET   = 2'h3;
	localparam logic        OSC_OUT_STANDBY  = 1'b1;
	localparam logic        OSC_IN_FORCED    = 1'b0;

	typedef enum logic [2:0] {
		PWR_ACTIVE  = 3'b001,
		PWR_SLEEP   = 3'b010,
		PWR_STANDBY = 3'b100
	} pwr_state_t;

	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
	} port_drive_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       frame_err;
	} rx_char_t;

endpackage : lowpower_pkg

// ==== src/serial_rx.sv ====
/*
 * Oversampling asynchronous receiver, 8 data bits, one stop bit.
 * Assumes rx_tick pulses sixteen times per nominal bit time.
 */
`timescale 1ns/100ps
module serial_rx (
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire logic                 rx_tick,
	input  wire logic                 rx_line,
	output lowpower_pkg::rx_char_t    rx_char
);
	import lowpower_pkg::*;

	logic       busy_q,  busy_d;
	logic [3:0] phase_q, phase_d;
	logic [3:0] bitn_q,  bitn_d;
	logic [7:0] shift_q, shift_d;
	rx_char_t   out_q,   out_d;

	// Sampling once in the bit centre and resynchronising on every start edge
	// gives +/-37.5 percent per-bit margin and the stated character margin.
	always_comb begin
		busy_d  = busy_q;
		phase_d = phase_q;
		bitn_d  = bitn_q;
		shift_d = shift_q;
		out_d   = out_q;
		out_d.valid = 1'b0;
		if (rx_tick) begin
			if (!busy_q) begin
				if (!rx_line) begin // see R6
					busy_d  = 1'b1;
					phase_d = 4'h0;
					bitn_d  = 4'h0;
				end
			end else begin
				phase_d = phase_q + 4'h1;
				if (phase_q == RX_CENTRE) begin // see R6
					if (bitn_q == 4'h0 && rx_line) begin
						busy_d = 1'b0;
					end else if (bitn_q == RX_BITS) begin
						busy_d          = 1'b0;
						out_d.valid     = 1'b1;
						out_d.data      = shift_q;
						out_d.frame_err = !rx_line;
					end else if (bitn_q != 4'h0) begin
						shift_d = {rx_line, shift_q[7:1]};
					end
					bitn_d = bitn_q + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			busy_q  <= 1'b0;
			phase_q <= 4'h0;
			bitn_q  <= 4'h0;
			shift_q <= 8'h00;
			out_q   <= '0;
		end else begin
			busy_q  <= busy_d;
			phase_q <= phase_d;
			bitn_q  <= bitn_d;
			shift_q <= shift_d;
			out_q   <= out_d;
		end
	end

	assign rx_char = out_q;

	AST_RX_CENTRE: assert property (@(posedge sys_clk) disable iff (rst) // see R6
		out_q.valid |-> $past(phase_q) == RX_CENTRE && $past(bitn_q) == RX_BITS)
		else $error("character completed off the bit centre");

endmodule : serial_rx

// ==== src/lowpower_pins_reset_misc.sv ====
/*
 * Power state, pin enable, mode decode, reset sync and write-only read-back logic.
 * Assumes the core supplies sleep/standby requests, bus phase and read strobes.
 */
// Notes on behaviour
// R1: In sleep, supply, clock, input and bus phase pins behave as in operation.
// R2: In standby only supply and standby request stay live; others float.
// R3: Standby forces the oscillator input internally and holds oscillator output constant.
// R4: Mode 2 acts as multiplexed mode 4; mode 3 is undefined.
// R5: Outside logic latches address on strobe fall or bus phase rise.
// R6: Receiver tolerates 37.5 percent bit and +3.75/-2.5 percent character error.
// R7: Outside logic must not freeze the bus during interrupt-idle instruction.
// R8: Reads of write-only registers return all ones.
// R9: Software must not use bit read-modify-write on direction registers.
// R10: Master clear must be held low at least 20 ms at power-up; the bench holds it low for 12 cycles (240 ns).
// R11: Master clear is sampled on the internal clock before taking effect.
// R12: Outside circuitry fixes port levels while the oscillator stabilises.
// R13: During reset the first port floats as input in every mode.
`timescale 1ns/100ps
module lowpower_pins_reset_misc (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic                   master_clear_n,
	input  wire logic                   standby_request_n,
	input  wire logic                   sleep_request,
	input  wire logic                   wake_event,
	input  wire logic [2:0]             mode_pins,
	input  wire logic                   osc_input,
	input  wire logic                   bus_phase_in,
	input  wire logic                   address_strobe_in,
	input  wire logic [7:0]             port1_core_o,
	input  wire logic [7:0]             port1_core_oe,
	input  wire logic                   wronly_sel,
	input  wire logic [7:0]             reg_rdata,
	input  wire logic                   rx_tick,
	input  wire logic                   rx_line,
	output lowpower_pkg::port_drive_t   port1_drive,
	output logic                        bus_phase_o,
	output logic                        bus_phase_oe,
	output logic                        address_strobe_o,
	output logic                        address_strobe_oe,
	output logic                        osc_output,
	output logic                        osc_gated,
	output logic                        core_reset,
	output logic [2:0]                  mode_eff,
	output logic                        mode_multiplexed,
	output logic                        mode_undefined,
	output logic [7:0]                  read_data,
	output lowpower_pkg::pwr_state_t    pwr_state,
	output lowpower_pkg::rx_char_t      rx_char
);
	import lowpower_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Reset synchroniser. The first stage feeds only the second stage.

	logic [1:0] clr_sync_q, clr_sync_d;

	always_comb begin
		clr_sync_d = {clr_sync_q[0], !master_clear_n}; // see R11
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			clr_sync_q <= RST_SYNC_RESET;
		end else begin
			clr_sync_q <= clr_sync_d;
		end
	end

	logic int_reset;
	assign int_reset = rst | clr_sync_q[1]; // see R11

	////////////////////////////////////////////////////////////////////////////////
	// Power state machine.

	pwr_state_t state_q, state_d;

	always_comb begin
		state_d = state_q;
		case (state_q)
			PWR_ACTIVE: begin
				if (!standby_request_n) begin
					state_d = PWR_STANDBY;
				end else if (sleep_request) begin
					state_d = PWR_SLEEP;
				end
			end
			PWR_SLEEP: begin
				if (!standby_request_n) begin
					state_d = PWR_STANDBY;
				end else if (wake_event) begin
					state_d = PWR_ACTIVE;
				end
			end
			PWR_STANDBY: begin
				// Leaving standby goes straight to active once standby_request_n is high, without passing through reset.
				if (standby_request_n) begin
					state_d = PWR_ACTIVE;
				end
			end
			default: begin
				state_d = PWR_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (int_reset) begin
			state_q <= PWR_ACTIVE;
		end else begin
			state_q <= state_d;
		end
	end

	logic in_standby;
	assign in_standby = (state_q == PWR_STANDBY);
	assign pwr_state  = state_q;

	////////////////////////////////////////////////////////////////////////////////
	// Mode capture at reset release.

	function automatic logic [2:0] map_mode(input logic [2:0] m);
		if (m == MODE_MUX_ALT) begin
			return MODE_MUX; // see R4
		end else begin
			return m;
		end
	endfunction : map_mode

	logic [2:0] mode_q, mode_d;

	always_comb begin
		mode_d = mode_q;
		if (int_reset) begin
			mode_d = map_mode(mode_pins);
		end
	end

	// Mode is latched from the strap pins while reset holds, clocked, never async.
	always_ff @(posedge sys_clk) begin
		mode_q <= mode_d;
	end

	assign mode_eff         = mode_q;
	assign mode_multiplexed = (mode_q == MODE_MUX); // see R4
	assign mode_undefined   = (mode_q == MODE_UNDEF); // see R4

	////////////////////////////////////////////////////////////////////////////////
	// Pin drive and oscillator handling.

	port_drive_t p1_q, p1_d;
	logic        bp_o_q, bp_o_d, bp_oe_q, bp_oe_d;
	logic        sb_o_q, sb_o_d, sb_oe_q, sb_oe_d;
	logic        osc_q, osc_d;
	logic [7:0]  rd_q, rd_d;

	always_comb begin
		p1_d    = '{o: port1_core_o, oe: port1_core_oe};
		bp_o_d  = bus_phase_in; // see R1
		bp_oe_d = 1'b1; // see R1
		sb_o_d  = address_strobe_in;
		sb_oe_d = mode_multiplexed;
		osc_d   = osc_input;
		if (int_reset) begin
			p1_d.oe = 8'h00; // see R13
		end
		if (in_standby) begin
			p1_d.oe = 8'h00; // see R2
			bp_oe_d = 1'b0; // see R2
			sb_oe_d = 1'b0; // see R2
			osc_d   = OSC_IN_FORCED; // see R3
		end
		rd_d = wronly_sel ? WRONLY_READ : reg_rdata; // see R8
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			p1_q    <= '0;
			bp_o_q  <= 1'b0;
			bp_oe_q <= 1'b0;
			sb_o_q  <= 1'b0;
			sb_oe_q <= 1'b0;
			osc_q   <= OSC_IN_FORCED;
			rd_q    <= 8'h00;
		end else begin
			p1_q    <= p1_d;
			bp_o_q  <= bp_o_d;
			bp_oe_q <= bp_oe_d;
			sb_o_q  <= sb_o_d;
			sb_oe_q <= sb_oe_d;
			osc_q   <= osc_d;
			rd_q    <= rd_d;
		end
	end

	assign port1_drive       = p1_q;
	assign bus_phase_o       = bp_o_q;
	assign bus_phase_oe      = bp_oe_q;
	assign address_strobe_o  = sb_o_q;
	assign address_strobe_oe = sb_oe_q;
	assign osc_gated         = osc_q;
	assign osc_output        = in_standby ? OSC_OUT_STANDBY : !osc_input; // see R3
	assign core_reset        = int_reset;
	assign read_data         = rd_q;

	////////////////////////////////////////////////////////////////////////////////
	// Serial receiver.

	serial_rx u_rx (
		.sys_clk (sys_clk),
		.rst     (int_reset),
		.rx_tick (rx_tick),
		.rx_line (rx_line),
		.rx_char (rx_char)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	AST_RESET_SYNC: assert property (@(posedge sys_clk) disable iff (rst) // see R11
		$rose(!master_clear_n) |-> !core_reset ##1 1'b1 ##1 core_reset)
		else $error("master clear not synchronised in two cycles");
	AST_STANDBY_FLOAT: assert property (@(posedge sys_clk) disable iff (rst) // see R2
		in_standby && $past(in_standby) |-> port1_drive.oe == 8'h00 && !bus_phase_oe
			&& !address_strobe_oe)
		else $error("pin driven in standby");
	AST_OSC_FORCED: assert property (@(posedge sys_clk) disable iff (rst) // see R3
		in_standby && $past(in_standby) |-> osc_gated == OSC_IN_FORCED
			&& osc_output == OSC_OUT_STANDBY)
		else $error("oscillator not forced in standby");
	AST_SLEEP_PHASE: assert property (@(posedge sys_clk) disable iff (rst) // see R1
		state_q == PWR_SLEEP && $past(state_q) == PWR_SLEEP |-> bus_phase_oe
			&& bus_phase_o == $past(bus_phase_in))
		else $error("bus phase pin not live in sleep");
	AST_MODE2_MAP: assert property (@(posedge sys_clk) disable iff (rst) // see R4
		$fell(int_reset) && $past(mode_pins) == MODE_MUX_ALT |-> mode_eff == MODE_MUX)
		else $error("mode 2 not mapped to multiplexed mode");
	AST_WRONLY_ONES: assert property (@(posedge sys_clk) disable iff (rst) // see R8
		wronly_sel |=> read_data == WRONLY_READ)
		else $error("write-only read not all ones");
	AST_RESET_PORT_IN: assert property (@(posedge sys_clk) disable iff (rst) // see R13
		int_reset ##1 int_reset |-> port1_drive.oe == 8'h00)
		else $error("first port driven during reset");
	AST_STANDBY_ENTRY: assert property (@(posedge sys_clk) disable iff (int_reset) // see R2
		!standby_request_n && !in_standby |=> in_standby)
		else $error("standby not entered in one cycle");

endmodule : lowpower_pins_reset_misc

// ==== testbench/serial_peer.sv ====
/*
 * Far-side model: a serial sender with its own sample tick.
 * Assumes the bench calls send_char and holds rst through the start.
 */
`timescale 1ns/100ps
module serial_peer (
	input  wire logic sys_clk,
	input  wire logic rst,
	output logic      rx_tick,
	output logic      rx_line
);
	logic [1:0] div_q;
	initial rx_line = 1'b1;
	// Sixteen ticks per bit gives a nominal bit of 64 clock cycles.
	always_ff @(posedge sys_clk) begin
		div_q   <= rst ? 2'h0 : div_q + 2'h1;
		rx_tick <= div_q == 2'h3;
	end
	// One bit, index si, may be given its own width to model bit distortion.
	task automatic send_char(input logic [7:0] d, input int w, input int sw, input int si,
		input logic stop);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge sys_clk);
			rx_line = f[i];
			repeat ((i == si ? sw : w) - 1) @(negedge sys_clk);
		end
		@(negedge sys_clk);
		rx_line = 1'b1;
	endtask : send_char
endmodule : serial_peer

// ==== testbench/tb_top.sv ====
/*
 * Self-checking bench for the power state, pin, mode, reset and receive logic.
 * Assumes the package and both design modules are compiled first.
 */
`timescale 1ns/100ps
module tb_top;
	import lowpower_pkg::*;
	typedef struct packed {
		logic [2:0] m;
		logic [2:0] eff;
		logic       mux;
		logic       und;
	} mode_row_t;
	typedef struct {
		logic [7:0] d;
		int         w;
		int         sw;
		int         si;
		logic       stop;
	} rx_row_t;
	logic        sys_clk, rst, master_clear_n, standby_request_n, sleep_request, wake_event;
	logic        osc_input, bus_phase_in, address_strobe_in, wronly_sel, rx_tick, rx_line;
	logic [2:0]  mode_pins, mode_eff;
	logic [7:0]  port1_core_o, port1_core_oe, reg_rdata, read_data;
	port_drive_t port1_drive;
	logic        bus_phase_o, bus_phase_oe, address_strobe_o, address_strobe_oe;
	logic        osc_output, osc_gated, core_reset, mode_multiplexed, mode_undefined;
	pwr_state_t  pwr_state;
	rx_char_t    rx_char;
	int          fails = 0;
	int          checks = 0;
	int          cycles = 0;
	mode_row_t   mrows [5] = '{'{3'h3, 3'h3, 1'b0, 1'b1}, '{3'h5, 3'h5, 1'b0, 1'b0},
		'{3'h7, 3'h7, 1'b0, 1'b0}, '{3'h2, 3'h4, 1'b1, 1'b0}, '{3'h4, 3'h4, 1'b1, 1'b0}};
	// Nominal, one short bit, one long bit, slow and fast characters, bad stop bit.
	rx_row_t     rrows [6] = '{'{8'ha5, 64, 64, 0, 1'b1}, '{8'h3c, 64, 40, 3, 1'b1},
		'{8'hc3, 64, 88, 5, 1'b1}, '{8'h5a, 62, 62, 0, 1'b1}, '{8'h96, 66, 66, 0, 1'b1},
		'{8'h81, 64, 64, 0, 1'b0}};

	logic        strobe_prev;
	logic [7:0]  addr_latch;

	lowpower_pins_reset_misc dut (
		.sys_clk           (sys_clk),
		.rst               (rst),
		.master_clear_n    (master_clear_n),
		.standby_request_n (standby_request_n),
		.sleep_request     (sleep_request),
		.wake_event        (wake_event),
		.mode_pins         (mode_pins),
		.osc_input         (osc_input),
		.bus_phase_in      (bus_phase_in),
		.address_strobe_in (address_strobe_in),
		.port1_core_o      (port1_core_o),
		.port1_core_oe     (port1_core_oe),
		.wronly_sel        (wronly_sel),
		.reg_rdata         (reg_rdata),
		.rx_tick           (rx_tick),
		.rx_line           (rx_line),
		.port1_drive       (port1_drive),
		.bus_phase_o       (bus_phase_o),
		.bus_phase_oe      (bus_phase_oe),
		.address_strobe_o  (address_strobe_o),
		.address_strobe_oe (address_strobe_oe),
		.osc_output        (osc_output),
		.osc_gated         (osc_gated),
		.core_reset        (core_reset),
		.mode_eff          (mode_eff),
		.mode_multiplexed  (mode_multiplexed),
		.mode_undefined    (mode_undefined),
		.read_data         (read_data),
		.pwr_state         (pwr_state),
		.rx_char           (rx_char)
	);
	serial_peer peer (
		.sys_clk (sys_clk),
		.rst     (rst),
		.rx_tick (rx_tick),
		.rx_line (rx_line)
	);

	// Far-side address latch: it takes the port on the strobe's falling edge only.
	always @(posedge sys_clk) begin
		strobe_prev <= address_strobe_o;
		if (strobe_prev && !address_strobe_o) begin
			addr_latch <= port1_drive.o;
		end
	end

	////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 8000) begin
			fails++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : tick
	task automatic rx_wait(input rx_row_t r);
		int n;
		n = 0;
		while (rx_char.valid !== 1'b1 && n < 900) begin
			@(negedge sys_clk);
			n++;
		end
		check("rx_valid", rx_char.valid, 1'b1);
		check("rx_data", rx_char.data, r.d);
		check("rx_frame_err", rx_char.frame_err, !r.stop);
	endtask : rx_wait

	////////////////////////////////////////////////////////////
	initial begin
		{rst, master_clear_n, standby_request_n} = 3'b101;
		{sleep_request, wake_event, osc_input, bus_phase_in, address_strobe_in} = 5'h00;
		wronly_sel = 1'b0;
		mode_pins = 3'h4;
		// Port levels are fixed from time zero so nothing floats before reset lands.
		port1_core_o = 8'h5a;
		port1_core_oe = 8'hff;
		reg_rdata = 8'h3c;
		tick(12);
		check("p1_oe_rst", port1_drive.oe, 8'h00);
		rst = 1'b0;
		master_clear_n = 1'b1;
		tick(1);
		check("core_rst_hold", core_reset, 1'b1);
		tick(1);
		check("core_rst_rel", core_reset, 1'b0);
		master_clear_n = 1'b0;
		tick(1);
		check("core_rst_e1", core_reset, 1'b0);
		tick(1);
		check("core_rst_e2", core_reset, 1'b1);
		$display("test reset done");
		foreach (mrows[i]) begin
			mode_pins = mrows[i].m;
			master_clear_n = 1'b0;
			tick(4);
			check("p1_oe_mclr", port1_drive.oe, 8'h00);
			master_clear_n = 1'b1;
			tick(3);
			check("mode_eff", mode_eff, mrows[i].eff);
			check("mode_mux", mode_multiplexed, mrows[i].mux);
			check("mode_undef", mode_undefined, mrows[i].und);
			check("strobe_oe", address_strobe_oe, mrows[i].mux);
		end
		$display("test modes done");
		foreach (rrows[i]) begin
			fork
				peer.send_char(rrows[i].d, rrows[i].w, rrows[i].sw, rrows[i].si, rrows[i].stop);
				rx_wait(rrows[i]);
			join
			tick(4);
		end
		$display("test serial done");
		// The bench never merges a write-only read back into a direction register.
		wronly_sel = 1'b1;
		reg_rdata = 8'h00;
		tick(1);
		check("rd_wronly", read_data, WRONLY_READ);
		wronly_sel = 1'b0;
		tick(1);
		check("rd_normal", read_data, 8'h00);
		$display("test readback done");
		// No bus-freeze request exists here, so none can land in an idle wait.
		sleep_request = 1'b1;
		tick(1);
		sleep_request = 1'b0;
		bus_phase_in = 1'b1;
		osc_input = 1'b1;
		address_strobe_in = 1'b1;
		tick(2);
		check("pwr_sleep", pwr_state, PWR_SLEEP);
		check("phase_o", bus_phase_o, 1'b1);
		check("phase_oe", bus_phase_oe, 1'b1);
		check("osc_out_slp", osc_output, 1'b0);
		check("osc_g_slp", osc_gated, 1'b1);
		check("p1_o_slp", port1_drive.o, 8'h5a);
		check("strobe_o_slp", address_strobe_o, 1'b1);
		address_strobe_in = 1'b0;
		wake_event = 1'b1;
		tick(1);
		wake_event = 1'b0;
		tick(1);
		check("pwr_wake", pwr_state, PWR_ACTIVE);
		check("addr_latch", addr_latch, 8'h5a);
		$display("test sleep done");
		standby_request_n = 1'b0;
		sleep_request = 1'b1;
		tick(3);
		check("pwr_standby_request_n", pwr_state, PWR_STANDBY);
		check("p1_oe_standby_request_n", port1_drive.oe, 8'h00);
		check("phase_oe_standby_request_n", bus_phase_oe, 1'b0);
		check("strobe_oe_standby_request_n", address_strobe_oe, 1'b0);
		// A high pin level would show through if the input were not forced.
		osc_input = 1'b1;
		tick(1);
		check("osc_out_standby_request_n", osc_output, OSC_OUT_STANDBY);
		check("osc_g_standby_request_n", osc_gated, OSC_IN_FORCED);
		sleep_request = 1'b0;
		tick(1);
		standby_request_n = 1'b1;
		tick(2);
		check("pwr_exit", pwr_state, PWR_ACTIVE);
		$display("test standby done");
		print_verdict();
	end
endmodule : tb_top
